// ===== logic/hascp_pkg.sv
// Constants, codes and types of the hex/ASCII serial console path.
// Assumes one 25 MHz controller clock and an active-high master clear.
package hascp_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int BIT_RATE_HZ = 9600;
    localparam int OVERSAMPLE = 16;
    localparam int TICK_DIV = CLK_HZ / (BIT_RATE_HZ * OVERSAMPLE);

    localparam int CHAR_BITS = 7;
    localparam int NIB_BITS = 4;
    localparam int CODE_BITS = 3;
    localparam int LUT_DEPTH = 32;

    localparam logic [1:0] SRC_CODE_LSB = 2'h0;
    localparam logic [1:0] SRC_TOP_BIT = 2'h1;
    localparam logic [1:0] SRC_ALU = 2'h2;
    localparam logic [1:0] SRC_BUFFER = 2'h3;

    localparam logic [1:0] TXS_ABOVE = 2'h0;
    localparam logic [1:0] TXS_BELOW = 2'h1;
    localparam logic [1:0] TXS_INSTR = 2'h2;
    localparam logic [1:0] TXS_CODE = 2'h3;

    localparam logic [1:0] BUF_HOLD = 2'h0;
    localparam logic [1:0] BUF_RIGHT = 2'h1;
    localparam logic [1:0] BUF_LEFT = 2'h2;
    localparam logic [1:0] BUF_LOAD = 2'h3;

    localparam logic [2:0] ZONE_DIGIT = 3'h3;
    localparam logic [2:0] ZONE_LETTER = 3'h4;
    localparam logic [3:0] MAX_DEC_DIGIT = 4'h9;

    localparam int LUT_LEGAL_BIT = 7;
    localparam int LUT_DIGIT_BIT = 6;
    localparam int LUT_TERM_BIT = 5;
    localparam int LUT_RESTART_BIT = 4;

    localparam int SYNC_W = 11;
    localparam logic [10:0] SYNC_RST = 11'h402;
    localparam logic [3:0] BUF_RST = 4'h0;
    localparam logic [2:0] CODE_RST = 3'h0;
    localparam logic HALF_RST = 1'b0;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hascp_rx_state_type;

endpackage

// ===== logic/hascp_serial.sv
// Serial receiver/transmitter: start bit, seven data bits LSB first, one stop bit.
// Assumes a one-cycle tick at sixteen times the bit rate and a synchronised input.
`timescale 1ns/1ns
module hascp_serial
    import hascp_pkg::*;
#(
    parameter int DATA_BITS = CHAR_BITS,
    parameter int OVER = OVERSAMPLE
)(
    // Clock and clears
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic tick_i,
    // Transmit side
    input wire logic load_i,
    input wire logic [DATA_BITS-1:0] tx_data_i,
    output logic tx_o,
    output logic tx_busy_o,
    // Receive side
    input wire logic rx_i,
    input wire logic ready_clear_i,
    output logic [DATA_BITS-1:0] rx_data_o,
    output logic rx_ready_o
);
    localparam int CW = $clog2(OVER);
    localparam int BW = $clog2(DATA_BITS + 3);

    if (OVER < 4 || (OVER & (OVER - 1)) != 0) begin : g_chk
        $error("OVER must be a power of two of at least four");
    end

    logic [DATA_BITS-1:0] buf_r;
    logic buf_full_r;
    logic [DATA_BITS+1:0] frame_r;
    logic [BW-1:0] bits_r;
    logic [CW-1:0] tx_ph_r;
    hascp_rx_state_type rx_st_r;
    logic [CW-1:0] rx_cnt_r;
    logic [BW-1:0] rx_idx_r;
    logic [DATA_BITS-1:0] rx_sh_r;
    logic rx_done;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            buf_r <= '0;
            buf_full_r <= 1'b0;
            frame_r <= '1;
            bits_r <= '0;
            tx_ph_r <= '0;
            tx_busy_o <= 1'b0;
            tx_o <= 1'b1;
        end else if (clear_i) begin
            buf_full_r <= 1'b0;
            bits_r <= '0;
            tx_ph_r <= '0;
            tx_busy_o <= 1'b0;
            tx_o <= 1'b1;
        end else begin
            if (!tx_busy_o && buf_full_r) begin
                frame_r <= {1'b1, buf_r, 1'b0};
                bits_r <= BW'(DATA_BITS + 2);
                tx_ph_r <= '0;
                tx_busy_o <= 1'b1;
                buf_full_r <= 1'b0;
            end else if (tx_busy_o && tick_i) begin
                tx_ph_r <= tx_ph_r + 1'b1;
                if (tx_ph_r == '0) begin
                    if (bits_r == '0) begin
                        tx_busy_o <= 1'b0;
                    end else begin
                        tx_o <= frame_r[0];
                        frame_r <= {1'b1, frame_r[DATA_BITS+1:1]};
                        bits_r <= bits_r - 1'b1;
                    end
                end
            end
            if (load_i) begin
                buf_r <= tx_data_i;
                buf_full_r <= 1'b1;
            end
        end
    end

    assign rx_done = (rx_st_r == RX_STOP) && tick_i && (rx_cnt_r == CW'(OVER - 1));

    // Start bit is checked at mid-bit, so a glitch shorter than half a bit is dropped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= '0;
            rx_idx_r <= '0;
            rx_sh_r <= '0;
            rx_data_o <= '0;
        end else if (clear_i) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= '0;
        end else if (tick_i) begin
            rx_cnt_r <= rx_cnt_r + 1'b1;
            case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (!rx_i) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_r == CW'(OVER / 2 - 1)) begin
                        rx_cnt_r <= '0;
                        rx_idx_r <= '0;
                        rx_st_r <= rx_i ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_r == CW'(OVER - 1)) begin
                        rx_sh_r <= {rx_i, rx_sh_r[DATA_BITS-1:1]};
                        rx_idx_r <= rx_idx_r + 1'b1;
                        if (rx_idx_r == BW'(DATA_BITS - 1)) begin
                            rx_st_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_r == CW'(OVER - 1)) begin
                        rx_st_r <= RX_IDLE;
                        rx_data_o <= rx_sh_r;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_ready_o <= 1'b0;
        end else if (clear_i) begin
            rx_ready_o <= 1'b0;
        end else if (rx_done) begin
            rx_ready_o <= 1'b1;
        end else if (ready_clear_i) begin
            rx_ready_o <= 1'b0;
        end
    end

    AST_READY_STICKS: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_ready_o && !ready_clear_i && !clear_i |=> rx_ready_o)
        else $error("ready dropped without clear");
    AST_READY_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
        ready_clear_i && !rx_done |=> !rx_ready_o)
        else $error("ready survived its clear");
    AST_LOAD_STARTS: assert property (@(posedge clk_i) disable iff (rst_i)
        load_i && !tx_busy_o && !clear_i |-> ##2 tx_busy_o)
        else $error("loaded character not started");

endmodule

// ===== logic/hascp_console.sv
// Character path between the panel datapath and a remote serial terminal.
// Assumes instruction fields and strobes come from same-clock sequencer logic.
`timescale 1ns/1ns
module hascp_console
    import hascp_pkg::*;
#(
    parameter int TICK_DIV_P = TICK_DIV
)(
    // Clock and master clear
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction fields
    input wire logic src_select_low_i,
    input wire logic src_select_high_i,
    input wire logic [1:0] buf_mode_i,
    input wire logic [6:0] instr_addr_i,
    // Instruction strobes
    input wire logic tx_buffer_load_i,
    input wire logic rx_ready_clear_i,
    input wire logic ctrl_char_strobe_i,
    input wire logic display_alt_i,
    // Datapath taps
    input wire logic [3:0] shifter_nibble_i,
    input wire logic alu_sel_top_bit_i,
    // Panel pins
    input wire logic local_switch_sense_i,
    input wire logic deadstart_flag_i,
    input wire logic [3:0] panel_switch_i,
    input wire logic [3:0] local_cond_i,
    // Serial line
    input wire logic serial_rx_i,
    output logic serial_tx_o,
    // Shifter serial inputs
    output logic ctrl_shifter_left_in_o,
    output logic panel_shifter_left_in_o,
    // Conditions
    output logic digit_at_most_nine_o,
    output logic half_select_o,
    output logic remote_select_o,
    output logic hex_digit_seen_o,
    output logic terminator_seen_o,
    output logic incoming_ready_cond_o,
    output logic restart_o,
    // Receive and transmit status
    output logic rx_char_ready_o,
    output logic rx_legal_o,
    output logic [7:0] rx_code_o,
    output logic tx_busy_o,
    // Held data
    output logic [3:0] shift_buf_o,
    output logic [2:0] ctrl_char_o
);
    localparam int DW = $clog2(TICK_DIV_P + 1);

    if (TICK_DIV_P < 2) begin : g_chk
        $error("TICK_DIV_P must be at least two");
    end

    function automatic logic [7:0] ascii_to_hex(input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            5'h00: v = 8'hc0;
            5'h01: v = 8'hc1;
            5'h02: v = 8'hc2;
            5'h03: v = 8'hc3;
            5'h04: v = 8'hc4;
            5'h05: v = 8'hc5;
            5'h06: v = 8'hc6;
            5'h07: v = 8'hc7;
            5'h08: v = 8'hc8;
            5'h09: v = 8'hc9;
            5'h0a: v = 8'ha0;
            5'h0f: v = 8'h90;
            5'h10: v = 8'ha0;
            5'h11: v = 8'hca;
            5'h12: v = 8'hcb;
            5'h13: v = 8'hcc;
            5'h14: v = 8'hcd;
            5'h15: v = 8'hce;
            5'h16: v = 8'hcf;
            5'h17: v = 8'ha0;
            5'h18: v = 8'h80;
            5'h19: v = 8'h81;
            5'h1a: v = 8'h82;
            5'h1b: v = 8'h83;
            5'h1c: v = 8'h84;
            5'h1d: v = 8'h85;
            5'h1e: v = 8'h86;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic local_s;
    logic dead_s;
    logic rx_s;
    logic [3:0] sw_s;
    logic [3:0] lcond_s;
    logic [DW-1:0] div_r;
    logic tick_r;
    logic [CHAR_BITS-1:0] rx_data;
    logic rx_ready;
    logic tx_busy;
    logic tx_line;
    logic [7:0] lut;
    logic legal;
    logic remote;
    logic [3:0] sel_data;
    logic [3:0] sel_cond;
    logic le9;
    logic [3:0] above_nib;
    logic [3:0] tx_nib;
    logic [CHAR_BITS-1:0] tx_char;
    logic ctrl_left;
    logic panel_left;
    logic half_r;
    logic [3:0] shift_buf_r;
    logic [2:0] ctrl_char_r;
    logic [1:0] src_sel;

    assign src_sel = {src_select_high_i, src_select_low_i};

    // Panel pins and the serial line are asynchronous to the controller clock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= SYNC_RST;
            sync_r <= SYNC_RST;
        end else begin
            meta_r <= {serial_rx_i, local_cond_i, panel_switch_i,
                       deadstart_flag_i, local_switch_sense_i};
            sync_r <= meta_r;
        end
    end

    assign local_s = sync_r[0];
    assign dead_s = sync_r[1];
    assign sw_s = sync_r[5:2];
    assign lcond_s = sync_r[9:6];
    assign rx_s = sync_r[10];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else if (local_s || div_r == DW'(TICK_DIV_P - 1)) begin
            div_r <= '0;
            tick_r <= !local_s;
        end else begin
            div_r <= div_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    hascp_serial #(
        .DATA_BITS(CHAR_BITS),
        .OVER(OVERSAMPLE)
    ) u_serial (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(local_s),
        .tick_i(tick_r),
        .load_i(tx_buffer_load_i),
        .tx_data_i(tx_char),
        .tx_o(tx_line),
        .tx_busy_o(tx_busy),
        .rx_i(rx_s),
        .ready_clear_i(rx_ready_clear_i),
        .rx_data_o(rx_data),
        .rx_ready_o(rx_ready)
    );

    assign lut = ascii_to_hex({rx_data[6], rx_data[3:0]});

    assign legal = (rx_data[6:4] == ZONE_DIGIT) || (rx_data[6:4] == ZONE_LETTER)
                   || lut[LUT_LEGAL_BIT];

    assign remote = !local_s || !dead_s;
    assign sel_data = remote ? lut[3:0] : sw_s;

    assign sel_cond = remote ? {lut[LUT_RESTART_BIT], rx_ready, lut[LUT_TERM_BIT],
                                lut[LUT_DIGIT_BIT]} : lcond_s;

    assign le9 = !(shifter_nibble_i[3] && (shifter_nibble_i[2] || shifter_nibble_i[1]));

    assign above_nib = {1'b0, shifter_nibble_i[2:0] - 3'h1};

    always_comb begin
        tx_nib = above_nib;
        case (src_sel)
            TXS_ABOVE: tx_nib = above_nib;
            TXS_BELOW: tx_nib = shifter_nibble_i;
            TXS_INSTR: tx_nib = instr_addr_i[3:0];
            // Bit 3 high so codes 000 to 100 come out as letters H to L
            TXS_CODE: tx_nib = {1'b1, ctrl_char_r};
            default: tx_nib = above_nib;
        endcase
    end

    assign tx_char = {instr_addr_i[6:4], tx_nib};

    // Left serial input choices for both shifters
    always_comb begin
        ctrl_left = ctrl_char_r[0];
        panel_left = half_r;
        case (src_sel)
            SRC_CODE_LSB: begin
                ctrl_left = ctrl_char_r[0];
                panel_left = half_r;
            end
            SRC_TOP_BIT: begin
                ctrl_left = shifter_nibble_i[3];
                panel_left = shifter_nibble_i[3];
            end
            SRC_ALU: begin
                ctrl_left = alu_sel_top_bit_i;
                panel_left = shifter_nibble_i[3];
            end
            SRC_BUFFER: begin
                ctrl_left = shift_buf_r[3];
                panel_left = shift_buf_r[3];
            end
            default: begin
                ctrl_left = ctrl_char_r[0];
                panel_left = half_r;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_r <= HALF_RST;
        end else if (src_select_low_i) begin
            half_r <= 1'b0;
        end else if (display_alt_i) begin
            half_r <= !half_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_buf_r <= BUF_RST;
        end else begin
            case (buf_mode_i)
                BUF_HOLD: shift_buf_r <= shift_buf_r;
                BUF_RIGHT: shift_buf_r <= {1'b0, shift_buf_r[3:1]};
                BUF_LEFT: shift_buf_r <= {shift_buf_r[2:0], shift_buf_r[3]};
                BUF_LOAD: shift_buf_r <= sel_data;
                default: shift_buf_r <= shift_buf_r;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_char_r <= CODE_RST;
        end else if (ctrl_char_strobe_i) begin
            ctrl_char_r <= sel_data[2:0];
        end
    end

    // Outputs are registered, so every selector answer lags its inputs by one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_shifter_left_in_o <= 1'b0;
            panel_shifter_left_in_o <= 1'b0;
            digit_at_most_nine_o <= 1'b0;
            remote_select_o <= 1'b0;
            hex_digit_seen_o <= 1'b0;
            terminator_seen_o <= 1'b0;
            incoming_ready_cond_o <= 1'b0;
            restart_o <= 1'b0;
            rx_legal_o <= 1'b0;
            rx_code_o <= 8'h00;
        end else begin
            ctrl_shifter_left_in_o <= ctrl_left;
            panel_shifter_left_in_o <= panel_left;
            digit_at_most_nine_o <= le9;
            remote_select_o <= remote;
            hex_digit_seen_o <= sel_cond[0];
            terminator_seen_o <= sel_cond[1];
            incoming_ready_cond_o <= sel_cond[2];
            restart_o <= sel_cond[3];
            rx_legal_o <= legal;
            rx_code_o <= lut;
        end
    end

    assign serial_tx_o = tx_line;
    assign tx_busy_o = tx_busy;
    assign rx_char_ready_o = rx_ready;
    assign half_select_o = half_r;
    assign shift_buf_o = shift_buf_r;
    assign ctrl_char_o = ctrl_char_r;

    AST_CODE_LSB: assert property (@(posedge clk_i) disable iff (rst_i)
        src_sel == SRC_CODE_LSB |=> ctrl_shifter_left_in_o == $past(ctrl_char_r[0]))
        else $error("code bit not fed to shifter");
    AST_ROTATE: assert property (@(posedge clk_i) disable iff (rst_i)
        src_sel == SRC_TOP_BIT |=> ctrl_shifter_left_in_o == $past(shifter_nibble_i[3]))
        else $error("top bit not fed back");
    AST_ALU_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
        src_sel == SRC_ALU |=> ctrl_shifter_left_in_o == $past(alu_sel_top_bit_i))
        else $error("ALU bit not fed to shifter");
    AST_HALF_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
        src_select_low_i |=> !half_select_o)
        else $error("half flag not forced low");
    AST_HALF_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i)
        display_alt_i && !src_select_low_i |=> half_select_o != $past(half_select_o))
        else $error("half flag did not toggle");
    AST_LE9: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> digit_at_most_nine_o == ($past(shifter_nibble_i) <= MAX_DEC_DIGIT))
        else $error("digit decode wrong");
    AST_ABOVE9: assert property (@(posedge clk_i) disable iff (rst_i)
        shifter_nibble_i > MAX_DEC_DIGIT && src_sel == TXS_ABOVE
        |-> tx_char[3:0] == shifter_nibble_i - MAX_DEC_DIGIT)
        else $error("letter conversion wrong");
    AST_BUF_ROT: assert property (@(posedge clk_i) disable iff (rst_i)
        buf_mode_i == BUF_LEFT ##1 buf_mode_i == BUF_LEFT ##1 buf_mode_i == BUF_LEFT
        ##1 buf_mode_i == BUF_LEFT |=> shift_buf_o == $past(shift_buf_o, 4))
        else $error("four rotates lost data");
    AST_BUF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        buf_mode_i == BUF_HOLD |=> $stable(shift_buf_o))
        else $error("buffer moved on hold");
    AST_CCR: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_char_strobe_i |=> ctrl_char_o == $past(sel_data[2:0]))
        else $error("control code not captured");
    AST_REMOTE: assert property (@(posedge clk_i) disable iff (rst_i)
        !local_s |=> remote_select_o)
        else $error("remote not selected");
    AST_LOCAL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        local_s |=> !rx_char_ready_o && !tx_busy_o)
        else $error("serial unit active while local");

    COV_TOGGLE: cover property (@(posedge clk_i) disable iff (rst_i)
        display_alt_i && !src_select_low_i);
    COV_RX_READY: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(rx_char_ready_o));
    COV_TX_CODE: cover property (@(posedge clk_i) disable iff (rst_i)
        tx_buffer_load_i && src_sel == TXS_CODE);
    COV_CTRL_REMOTE: cover property (@(posedge clk_i) disable iff (rst_i)
        ctrl_char_strobe_i && remote);

endmodule

// ===== dv/hascp_term_model.sv
// Serial terminal model: decodes 7N1 frames from the console and sends frames on request.
// Assumes a bit period of sixteen ticks of the console's divided clock.
`timescale 1ns/1ns
module hascp_term_model #(
    parameter int BIT_NS = 1280
)(
    // Serial pair
    input wire logic line_i,
    output logic line_o,
    // Decoded character
    output logic [6:0] char_o,
    output logic got_o
);
    initial begin
        line_o = 1'b1;
        got_o = 1'b0;
        char_o = 7'h00;
    end
    task automatic send(input logic [6:0] c);
        line_o = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 7; i++) begin
            line_o = c[i];
            #(BIT_NS);
        end
        line_o = 1'b1;
        #(BIT_NS);
    endtask
    always @(negedge line_i) begin
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 7; i++) begin
            char_o[i] = line_i;
            #(BIT_NS);
        end
        got_o = 1'b1;
        #(BIT_NS / 4);
        got_o = 1'b0;
    end
endmodule

// ===== dv/hascp_console_tb.sv
// Testbench of the console path: digit transmit, literal and code transmit, lookup.
// Assumes a tick divider of 2, so one serial bit lasts 32 clocks.
`timescale 1ns/1ns
module hascp_console_tb import hascp_pkg::*; ;
    logic clk_i = 1'b0, rst_i = 1'b1, lo = 1'b0, hi = 1'b0, ld = 1'b0, clr = 1'b0;
    logic cs = 1'b0, alt = 1'b0, alu = 1'b0;
    logic loc = 1'b0, dsf = 1'b1, cl, pl, half, rmt, hs, ts, ic, rs;
    logic [3:0] lc = 4'h0, sbuf;
    logic [8:0] rx_e;
    logic [1:0] bm = 2'h0;
    logic [6:0] ins = 7'h00;
    logic [3:0] nib = 4'h0, pan = 4'h0;
    logic srx, stx, got, busy, rdy, legal, le9;
    logic [6:0] ch;
    logic [7:0] code;
    logic [2:0] cc;
    logic [8:0] rxq[$];
    logic [6:0] txq[$];
    int err_count = 0, check_count = 0, seed = 32'h22cb882d;
    logic [31:0] r;
    always #20 clk_i = ~clk_i;
    hascp_console #(.TICK_DIV_P(2)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .src_select_low_i(lo), .src_select_high_i(hi),
        .buf_mode_i(bm), .instr_addr_i(ins), .tx_buffer_load_i(ld), .rx_ready_clear_i(clr),
        .ctrl_char_strobe_i(cs), .display_alt_i(alt), .shifter_nibble_i(nib),
        .alu_sel_top_bit_i(alu), .local_switch_sense_i(loc), .deadstart_flag_i(dsf),
        .panel_switch_i(pan), .local_cond_i(lc), .serial_rx_i(srx), .serial_tx_o(stx),
        .ctrl_shifter_left_in_o(cl), .panel_shifter_left_in_o(pl), .digit_at_most_nine_o(le9),
        .half_select_o(half), .remote_select_o(rmt), .hex_digit_seen_o(hs),
        .terminator_seen_o(ts), .incoming_ready_cond_o(ic), .restart_o(rs),
        .rx_char_ready_o(rdy), .rx_legal_o(legal), .rx_code_o(code), .tx_busy_o(busy),
        .shift_buf_o(sbuf), .ctrl_char_o(cc));
    hascp_term_model #(.BIT_NS(1280)) term (.line_i(stx), .line_o(srx), .char_o(ch), .got_o(got));
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Waits on busy, bounded, so a stuck transmitter cannot hang the run
    task automatic tx(input logic [1:0] s, input logic [6:0] a, input logic [6:0] e);
        {hi, lo} <= s;
        ins <= a;
        repeat (3) @(posedge clk_i);
        ld <= 1'b1;
        txq.push_back(e);
        @(posedge clk_i);
        ld <= 1'b0;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_i);
        chk("tx idle", 9'h000, {8'h00, busy});
        repeat (20) @(posedge clk_i);
    endtask
    // clear only after the character is taken
    task automatic rx(input logic [6:0] c, input logic [8:0] e);
        rxq.push_back(e);
        term.send(c);
        repeat (40) @(posedge clk_i);
        {clr, cs} <= 2'b11;
        @(posedge clk_i);
        {clr, cs} <= 2'b00;
        @(posedge clk_i);
    endtask
    always @(posedge got) chk("tx char", {2'b00, txq.pop_front()}, {2'b00, ch});
    always @(posedge rdy) begin
        repeat (2) @(posedge clk_i);
        rx_e = rxq.pop_front();
        chk("rx code", rx_e, {legal, code});
        chk("conds", {5'h00, rx_e[4], 1'b1, rx_e[5], rx_e[6]}, {5'h00, rs, ic, ts, hs});
    end
    initial begin
        logic [6:0] e;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int d = 0; d < 16; d++) begin
            r = $random(seed);
            {alu, alt, bm, pan} <= {r[8], r[7], r[6:5], r[3:0]};
            nib <= d[3:0];
            e = (d <= 9) ? {ZONE_DIGIT, d[3:0]} : {ZONE_LETTER, d[3:0] - 4'h9};
            tx((d <= 9) ? TXS_BELOW : TXS_ABOVE, {e[6:4], r[12:9]}, e);
            chk("le9", {8'h00, d <= 9}, {8'h00, le9});
        end
        r = $random(seed);
        tx(TXS_INSTR, r[6:0], r[6:0]);
        rx(7'h35, 9'h1c5);
        rx(7'h3a, 9'h1a0);
        rx(7'h41, 9'h1ca);
        rx(7'h2b, 9'h000);
        rx(7'h4a, 9'h182);
        chk("ctrl code", 9'h002, {6'h00, cc});
        tx(TXS_CODE, 7'h40, 7'h4a);
        // Left inputs and half flag, then the buffer as a shifter source
        {alt, alu, nib} <= 6'h08;
        {hi, lo} <= SRC_TOP_BIT;
        repeat (2) @(posedge clk_i);
        chk("left top", 9'h003, {7'h00, cl, pl});
        {hi, lo} <= SRC_ALU;
        repeat (2) @(posedge clk_i);
        chk("left alu", 9'h001, {7'h00, cl, pl});
        {hi, lo, alt} <= {SRC_CODE_LSB, 1'b1};
        @(posedge clk_i);
        alt <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("left code", 9'h003, {6'h00, cl, pl, half});
        bm <= BUF_LOAD;
        @(posedge clk_i);
        bm <= BUF_LEFT;
        repeat (2) @(posedge clk_i);
        {bm, hi, lo} <= {BUF_HOLD, SRC_BUFFER};
        repeat (2) @(posedge clk_i);
        chk("buffer", 9'h038, {3'h0, cl, pl, sbuf});
        bm <= BUF_RIGHT;
        @(posedge clk_i);
        bm <= BUF_HOLD;
        @(posedge clk_i);
        chk("buffer right", 9'h004, {5'h00, sbuf});
        // Local switch: panel data and local conditions, serial unit held off
        {loc, pan, lc, bm} <= {1'b1, 4'h5, 4'ha, BUF_LOAD};
        repeat (4) @(posedge clk_i);
        {ld, cs} <= 2'b11;
        @(posedge clk_i);
        {ld, cs} <= 2'b00;
        repeat (4) @(posedge clk_i);
        chk("local path", 9'h05a, {rmt, sbuf, rs, ic, ts, hs});
        chk("local serial", 9'h005, {5'h00, busy, cc});
        dsf <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("deadstart", 9'h001, {8'h00, rmt});
        {loc, dsf} <= 2'b01;
        chk("tx left", 9'h000, 9'(txq.size()));
        chk("rx left", 9'h000, 9'(rxq.size()));
        tally_and_finish;
    end
    initial begin
        #1_000_000;
        err_count++;
        tally_and_finish;
    end
endmodule
